// ---- src/mbi_boot_map.sv ----
`timescale 1ns/100ps
// Controller data-memory map with hardware boot initialisation
module mbi_boot_map (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [2:0] mem_space,
    input wire logic [15:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    input wire logic mem_bitval,
    input wire logic [1:0] bank_sel,
    output logic [7:0] mem_rdata,
    output logic mem_ack,
    output logic boot_busy,
    output logic dsp_idle,
    output logic tw_scl_hold_high,
    output logic tw_sda_hold_high,
    output logic fetch_from_ram,
    output logic delay_clear_req,
    output logic [7:0] output_mute_ctl_a,
    output logic [7:0] output_mute_ctl_b,
    output logic [7:0] output_mute_ctl_c,
    output logic [7:0] dac_mod_reset,
    output logic [7:0] adc_dec_reset,
    output logic [7:0] clock_config_primary,
    output logic [7:0] clock_skew_config_secondary
);
    typedef enum logic [2:0] {
        ST_IRAM, ST_XRAM, ST_DLY, ST_VARS, ST_HW, ST_RUN
    } mbi_boot_e;

    mbi_boot_e st_reg, st_next;
    logic [10:0] cnt_reg, cnt_next;
    logic [7:0] dly_reg, src_reg;
    logic [7:0] mute_a_reg, mute_b_reg, mute_c_reg, dac_reg, adc_reg;
    logic [7:0] clk_pri_reg, clk_sec_reg;
    logic [7:0] rdata_reg;
    logic ack_reg;

    // Bit address to the byte that holds it
    function automatic logic [7:0] bit_byte(input logic [7:0] ba);
        bit_byte = ba[7] ? {ba[7:3], 3'h0} : mbi_pkg::BITBYTE_BASE + {4'h0, ba[6:3]};
    endfunction

    // Replace one bit of a byte
    function automatic logic [7:0] put_bit(input logic [7:0] b, input logic [2:0] pos,
                                           input logic v);
        logic [7:0] r;
        r = b;
        r[pos] = v;
        put_bit = r;
    endfunction

    // Request decode; core access only once the boot walk is over
    wire take = mem_req && st_reg == ST_RUN;
    wire sp_dir = mem_space == mbi_pkg::MBI_SP_DIRECT;
    wire sp_ind = mem_space == mbi_pkg::MBI_SP_INDIRECT;
    wire sp_reg = mem_space == mbi_pkg::MBI_SP_BANKREG;
    wire sp_bit = mem_space == mbi_pkg::MBI_SP_BIT;
    wire sp_ext = mem_space == mbi_pkg::MBI_SP_EXT;
    wire dir_low = mem_addr[7:0] < mbi_pkg::DIRECT_LIMIT;
    wire [7:0] bit_adr = bit_byte(mem_addr[7:0]);
    wire [2:0] bit_pos = mem_addr[2:0];

    // Target selection: indirect hits RAM across the whole 256 bytes,
    // register-bank only 00-1F, direct only the low half
    wire hit_iram = sp_ind || sp_reg || (sp_dir && dir_low)
                    || (sp_bit && !mem_addr[7]);
    wire hit_esfr = (sp_dir && !dir_low) || (sp_bit && mem_addr[7])
                    || (sp_ext && mem_addr[15:8] == mbi_pkg::ESFR_PAGE);
    wire hit_xram = sp_ext && mem_addr <= mbi_pkg::XRAM_TOP;

    // Internal RAM address per space; bank registers fold into 00-1F
    wire [7:0] core_iram_addr = sp_reg ? {3'h0, bank_sel, mem_addr[2:0]}
                              : sp_bit ? bit_adr
                              : sp_dir ? {1'b0, mem_addr[6:0]}
                              : mem_addr[7:0];
    wire [7:0] esfr_idx = sp_bit ? bit_adr : mem_addr[7:0];

    // Extended register readback
    logic [7:0] esfr_rd;
    always_comb begin
        unique case (esfr_idx)
            mbi_pkg::ESFR_DLY_CTL: esfr_rd = dly_reg;
            mbi_pkg::ESFR_MUTE_A: esfr_rd = mute_a_reg;
            mbi_pkg::ESFR_MUTE_B: esfr_rd = mute_b_reg;
            mbi_pkg::ESFR_MUTE_C: esfr_rd = mute_c_reg;
            mbi_pkg::ESFR_DAC_RST: esfr_rd = dac_reg;
            mbi_pkg::ESFR_ADC_RST: esfr_rd = adc_reg;
            mbi_pkg::ESFR_CLK_PRI: esfr_rd = clk_pri_reg;
            mbi_pkg::ESFR_CLK_SEC: esfr_rd = clk_sec_reg;
            mbi_pkg::ESFR_FETCH_SRC: esfr_rd = src_reg;
            default: esfr_rd = 8'h00;
        endcase
    end

    logic [7:0] iram_rd, xram_rd;
    wire [7:0] byte_rd = hit_iram ? iram_rd : hit_xram ? xram_rd : hit_esfr ? esfr_rd : 8'h00;
    // Bit writes are a read-modify-write of the holding byte
    wire [7:0] core_wbyte = sp_bit ? put_bit(byte_rd, bit_pos, mem_bitval) : mem_wdata;
    wire core_wr = take && mem_we;
    wire esfr_wr = core_wr && hit_esfr;

    // Memory ports shared between the boot walk and the core
    wire boot_iram = st_reg == ST_IRAM;
    wire boot_xram = st_reg == ST_XRAM;
    wire iram_we = boot_iram || (core_wr && hit_iram);
    wire [7:0] iram_addr = boot_iram ? cnt_reg[7:0] : core_iram_addr;
    wire [7:0] iram_wd = boot_iram ? 8'h00 : core_wbyte;
    wire xram_we = boot_xram || (core_wr && hit_xram);
    wire [10:0] xram_addr = boot_xram ? cnt_reg : mem_addr[10:0];
    wire [7:0] xram_wd = boot_xram ? 8'h00 : core_wbyte;

    mbi_iram #(.DEPTH(mbi_pkg::IRAM_BYTES)) u_iram (
        .core_clk(core_clk),
        .we(iram_we),
        .addr(iram_addr),
        .wdata(iram_wd),
        .rdata(iram_rd)
    );

    mbi_xram #(.DEPTH(mbi_pkg::XRAM_BYTES)) u_xram (
        .core_clk(core_clk),
        .we(xram_we),
        .addr(xram_addr),
        .wdata(xram_wd),
        .rdata(xram_rd)
    );

    // Boot walk order is fixed; each clear writes one byte per cycle
    always_comb begin
        st_next = st_reg;
        cnt_next = cnt_reg + 11'h001;
        unique case (st_reg)
            ST_IRAM: if (cnt_reg == mbi_pkg::IRAM_LAST) begin
                st_next = ST_XRAM;
                cnt_next = 11'h000;
            end
            ST_XRAM: if (cnt_reg == mbi_pkg::XRAM_LAST) begin
                st_next = ST_DLY;
            end
            ST_DLY: st_next = ST_VARS;
            ST_VARS: st_next = ST_HW;
            ST_HW: st_next = ST_RUN;
            ST_RUN: cnt_next = cnt_reg;
        endcase
        if (st_reg == ST_DLY || st_reg == ST_VARS || st_reg == ST_HW) begin
            cnt_next = 11'h000;
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            st_reg <= ST_IRAM;
            cnt_reg <= 11'h000;
        end else begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
        end
    end

    // Delay-memory control: boot sets the clear bit, core owns it later
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            dly_reg <= mbi_pkg::ESFR_RESET_VAL;
        end else if (st_reg == ST_DLY) begin
            dly_reg <= dly_reg | (8'h01 << mbi_pkg::DLY_CLR_BIT);
        end else if (esfr_wr && esfr_idx == mbi_pkg::ESFR_DLY_CTL) begin
            dly_reg <= core_wbyte;
        end
    end

    // Default variables loaded ahead of the clock configuration
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            mute_a_reg <= mbi_pkg::ESFR_RESET_VAL;
            mute_b_reg <= mbi_pkg::ESFR_RESET_VAL;
            mute_c_reg <= mbi_pkg::ESFR_RESET_VAL;
            dac_reg <= mbi_pkg::ESFR_RESET_VAL;
            adc_reg <= mbi_pkg::ESFR_RESET_VAL;
        end else if (st_reg == ST_VARS) begin
            mute_a_reg <= mbi_pkg::MUTE_BOOT_VAL;
            mute_b_reg <= mbi_pkg::MUTE_BOOT_VAL;
            mute_c_reg <= mbi_pkg::MUTE_BOOT_VAL;
            dac_reg <= mbi_pkg::DAC_RST_BOOT_VAL;
            adc_reg <= mbi_pkg::ADC_RST_BOOT_VAL;
        end else if (esfr_wr) begin
            if (esfr_idx == mbi_pkg::ESFR_MUTE_A) mute_a_reg <= core_wbyte;
            if (esfr_idx == mbi_pkg::ESFR_MUTE_B) mute_b_reg <= core_wbyte;
            if (esfr_idx == mbi_pkg::ESFR_MUTE_C) mute_c_reg <= core_wbyte;
            if (esfr_idx == mbi_pkg::ESFR_DAC_RST) dac_reg <= core_wbyte;
            if (esfr_idx == mbi_pkg::ESFR_ADC_RST) adc_reg <= core_wbyte;
        end
    end

    // Clock configuration defaults
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            clk_pri_reg <= mbi_pkg::ESFR_RESET_VAL;
            clk_sec_reg <= mbi_pkg::ESFR_RESET_VAL;
        end else if (st_reg == ST_HW) begin
            clk_pri_reg <= mbi_pkg::CLK_PRI_BOOT_VAL;
            clk_sec_reg <= mbi_pkg::CLK_SEC_BOOT_VAL;
        end else if (esfr_wr) begin
            if (esfr_idx == mbi_pkg::ESFR_CLK_PRI) clk_pri_reg <= core_wbyte;
            if (esfr_idx == mbi_pkg::ESFR_CLK_SEC) clk_sec_reg <= core_wbyte;
        end
    end

    // Fetch source: only software after boot can move fetch to RAM,
    // the boot code itself is never writable
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            src_reg <= mbi_pkg::ESFR_RESET_VAL;
        end else if (esfr_wr && esfr_idx == mbi_pkg::ESFR_FETCH_SRC) begin
            src_reg <= core_wbyte;
        end
    end

    // Core answer one cycle after the request is taken
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            rdata_reg <= 8'h00;
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= take;
            if (take && !mem_we) begin
                rdata_reg <= sp_bit ? {7'h00, byte_rd[bit_pos]} : byte_rd;
            end
        end
    end

    // Outputs
    assign mem_rdata = rdata_reg;
    assign mem_ack = ack_reg;
    assign boot_busy = st_reg != ST_RUN;
    assign dsp_idle = boot_busy;
    assign tw_scl_hold_high = boot_busy;
    assign tw_sda_hold_high = boot_busy;
    assign fetch_from_ram = src_reg[mbi_pkg::FETCH_RAM_BIT];
    assign delay_clear_req = dly_reg[mbi_pkg::DLY_CLR_BIT];
    assign output_mute_ctl_a = mute_a_reg;
    assign output_mute_ctl_b = mute_b_reg;
    assign output_mute_ctl_c = mute_c_reg;
    assign dac_mod_reset = dac_reg;
    assign adc_dec_reset = adc_reg;
    assign clock_config_primary = clk_pri_reg;
    assign clock_skew_config_secondary = clk_sec_reg;

    // Checks
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);

    sequence s_iram_end;
        st_reg == ST_IRAM && cnt_reg == mbi_pkg::IRAM_LAST;
    endsequence
    sequence s_cfg_tail;
        st_reg == ST_DLY ##1 st_reg == ST_VARS ##1 st_reg == ST_HW;
    endsequence

    a_boot_pins_held: assert property (boot_busy
        |-> dsp_idle && tw_scl_hold_high && tw_sda_hold_high && !mem_ack)
        else $error("boot outputs wrong");
    a_iram_clear_end: assert property (s_iram_end
        |=> st_reg == ST_XRAM && cnt_reg == 11'h000)
        else $error("iram clear end");
    a_iram_zero_wr: assert property (st_reg == ST_IRAM
        |-> iram_we && iram_wd == 8'h00 && iram_addr == cnt_reg[7:0])
        else $error("iram clear write");
    a_xram_clear_len: assert property (st_reg == ST_XRAM
        && cnt_reg != mbi_pkg::XRAM_LAST
        |=> st_reg == ST_XRAM && cnt_reg == $past(cnt_reg) + 11'h001)
        else $error("xram clear length");
    a_xram_zero_wr: assert property (st_reg == ST_XRAM
        |-> xram_we && xram_wd == 8'h00 && xram_addr == cnt_reg)
        else $error("xram clear write");
    a_xram_clear_end: assert property (st_reg == ST_XRAM
        && cnt_reg == mbi_pkg::XRAM_LAST |=> st_reg == ST_DLY)
        else $error("xram clear end");
    a_dly_bit_set: assert property (st_reg == ST_DLY
        |=> dly_reg[3] && st_reg == ST_VARS)
        else $error("delay clear bit");
    a_cfg_sequence: assert property (s_cfg_tail
        |=> clk_pri_reg == 8'h0A && clk_sec_reg == 8'h05 && mute_a_reg == 8'h00
        && mute_c_reg == 8'h00 && dac_reg == 8'hFF && adc_reg == 8'h03 && !boot_busy)
        else $error("boot config values");
    a_vars_init: assert property (st_reg == ST_VARS
        |=> mute_b_reg == 8'h00 && dac_reg == 8'hFF && adc_reg == 8'h03)
        else $error("variable init");
    a_direct_upper: assert property (take && sp_dir && mem_addr[7]
        |-> !hit_iram && hit_esfr)
        else $error("direct upper decode");
    a_direct_lower: assert property (take && sp_dir && mem_we && !mem_addr[7]
        |-> iram_we && iram_addr[7] == 1'b0)
        else $error("direct lower decode");
    // Scratch pad bytes are reached directly at their own index
    a_scratch_direct: assert property (take && sp_dir
        && mem_addr[7:0] >= mbi_pkg::SCRATCH_BASE && mem_addr[7:0] <= mbi_pkg::SCRATCH_TOP
        |-> hit_iram && iram_addr == mem_addr[7:0])
        else $error("scratch pad decode");
    a_bank_window: assert property (take && sp_reg
        |-> iram_addr[7:5] == 3'h0 && iram_addr[4:3] == bank_sel)
        else $error("bank mapping");
    a_bit_region: assert property (take && sp_bit && !mem_addr[7]
        |-> iram_addr >= 8'h20 && iram_addr <= 8'h2F)
        else $error("bit region");
    a_fetch_write: assert property (esfr_wr && esfr_idx == 8'hFD
        |=> fetch_from_ram == $past(core_wbyte[0]))
        else $error("fetch source");
endmodule

// ---- src/mbi_iram.sv ----
`timescale 1ns/100ps
// Internal data memory, one write port and one combinational read port
module mbi_iram #(
    parameter int DEPTH = 256
) (
    input wire logic core_clk,
    input wire logic we,
    input wire logic [$clog2(DEPTH)-1:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);
    logic [7:0] mem_reg [DEPTH];

    // No reset: contents are zeroed by the boot sequence instead
    always_ff @(posedge core_clk) begin
        if (we) begin
            mem_reg[addr] <= wdata;
        end
    end

    assign rdata = mem_reg[addr];
endmodule

// ---- src/mbi_pkg.sv ----
// How it works
// - All 256 internal bytes reachable indirectly, stack too
// - Direct addressing hits RAM only below 0x80
// - Direct upper half goes to extended registers
// - Four register banks at 00-1F, one active
// - Bytes 20-2F support single-bit set/clear/test
// - Extended registers at 1XXXX000 are bit addressable
// - Bytes 30-7F are scratch pad or stack
// - 64K external space holds the extended registers
// - Boot code is fixed; applications run from RAM
// - During boot: DSP idle, two-wire lines high
// - First boot step clears 256 internal bytes
// - Then clear 2048 bytes of external RAM
// - Then set bit 3 of register 0xC0
// - Write 0x0A and 0x05 to clock configs
// - Fetch moves to RAM when 0xFD set
package mbi_pkg;
    // Access spaces offered to the core
    typedef enum logic [2:0] {
        MBI_SP_DIRECT, MBI_SP_INDIRECT, MBI_SP_BANKREG, MBI_SP_BIT, MBI_SP_EXT
    } mbi_space_e;

    // Internal and external memory geometry
    localparam int IRAM_BYTES = 256;
    localparam int XRAM_BYTES = 2048;
    localparam logic [7:0] DIRECT_LIMIT = 8'h80;
    localparam logic [7:0] BITBYTE_BASE = 8'h20;
    localparam logic [7:0] SCRATCH_BASE = 8'h30;
    localparam logic [7:0] SCRATCH_TOP = 8'h7F;
    localparam logic [15:0] XRAM_TOP = 16'h07FF;
    localparam logic [7:0] ESFR_PAGE = 8'hFF;

    // Extended register offsets
    localparam logic [7:0] ESFR_DLY_CTL = 8'hC0;
    localparam logic [7:0] ESFR_MUTE_A = 8'hC1;
    localparam logic [7:0] ESFR_MUTE_B = 8'hC2;
    localparam logic [7:0] ESFR_MUTE_C = 8'hC3;
    localparam logic [7:0] ESFR_DAC_RST = 8'hC4;
    localparam logic [7:0] ESFR_ADC_RST = 8'hC5;
    localparam logic [7:0] ESFR_CLK_PRI = 8'hC8;
    localparam logic [7:0] ESFR_CLK_SEC = 8'hC9;
    localparam logic [7:0] ESFR_FETCH_SRC = 8'hFD;

    // Field positions and boot values
    localparam int DLY_CLR_BIT = 3;
    localparam int FETCH_RAM_BIT = 0;
    localparam logic [7:0] ESFR_RESET_VAL = 8'h00;
    localparam logic [7:0] MUTE_BOOT_VAL = 8'h00;
    localparam logic [7:0] DAC_RST_BOOT_VAL = 8'hFF;
    localparam logic [7:0] ADC_RST_BOOT_VAL = 8'h03;
    localparam logic [7:0] CLK_PRI_BOOT_VAL = 8'h0A;
    localparam logic [7:0] CLK_SEC_BOOT_VAL = 8'h05;

    // Boot clear counts
    localparam logic [10:0] IRAM_LAST = 11'h0FF;
    localparam logic [10:0] XRAM_LAST = 11'h7FF;
endpackage

// ---- src/mbi_xram.sv ----
`timescale 1ns/100ps
// External data RAM of the controller, flip-flop storage
module mbi_xram #(
    parameter int DEPTH = 2048
) (
    input wire logic core_clk,
    input wire logic we,
    input wire logic [$clog2(DEPTH)-1:0] addr,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);
    logic [7:0] mem_reg [DEPTH];

    // Left unreset on purpose; the boot walk clears every byte
    always_ff @(posedge core_clk) begin
        if (we) begin
            mem_reg[addr] <= wdata;
        end
    end

    assign rdata = mem_reg[addr];
endmodule

// ---- test/mbi_boot_map_tb.sv ----
`timescale 1ns/100ps
// Bench for the memory map and boot walk; reads note their expected byte in a queue
module mbi_boot_map_tb;
    logic core_clk, reset, mem_req, mem_we, mem_bitval, mem_ack, ok;
    logic boot_busy, dsp_idle, tw_scl_hold_high, tw_sda_hold_high;
    logic fetch_from_ram, delay_clear_req;
    logic [2:0] mem_space;
    logic [15:0] mem_addr, r;
    logic [1:0] bank_sel;
    logic [7:0] mem_wdata, mem_rdata, output_mute_ctl_a, output_mute_ctl_b, output_mute_ctl_c;
    logic [7:0] dac_mod_reset, adc_dec_reset, clock_config_primary, clock_skew_config_secondary;
    logic [7:0] iram_m [256];
    logic [8:0] exp_q [$];
    logic [8:0] e;
    int errors, checks_done, n;

    mbi_boot_map u_dut (.core_clk(core_clk), .reset(reset), .mem_req(mem_req),
        .mem_we(mem_we), .mem_space(mem_space), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_bitval(mem_bitval), .bank_sel(bank_sel),
        .mem_rdata(mem_rdata), .mem_ack(mem_ack), .boot_busy(boot_busy),
        .dsp_idle(dsp_idle), .tw_scl_hold_high(tw_scl_hold_high),
        .tw_sda_hold_high(tw_sda_hold_high), .fetch_from_ram(fetch_from_ram),
        .delay_clear_req(delay_clear_req), .output_mute_ctl_a(output_mute_ctl_a),
        .output_mute_ctl_b(output_mute_ctl_b), .output_mute_ctl_c(output_mute_ctl_c),
        .dac_mod_reset(dac_mod_reset), .adc_dec_reset(adc_dec_reset),
        .clock_config_primary(clock_config_primary),
        .clock_skew_config_secondary(clock_skew_config_secondary));

    mbi_core_model u_core (.core_clk(core_clk), .mem_ack(mem_ack), .mem_req(mem_req),
        .mem_we(mem_we), .mem_space(mem_space), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_bitval(mem_bitval), .bank_sel(bank_sel));

    // 200 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("errors=%0d checks_done=%0d", errors, checks_done);
        if (errors == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // A missing answer is a mismatch in its own right
    task automatic rd(input logic [2:0] sp, input logic [15:0] ad, input logic [7:0] x);
        exp_q.push_back({1'b1, x});
        u_core.acc(1'b0, sp, ad, 8'h00, 1'b0, ok);
        chk({31'h0, ok}, 32'h1);
    endtask

    task automatic wr(input logic [2:0] sp, input logic [15:0] ad, input logic [7:0] d,
                      input logic bv);
        exp_q.push_back(9'h000);
        u_core.acc(1'b1, sp, ad, d, bv, ok);
        chk({31'h0, ok}, 32'h1);
    endtask

    // Every answer takes the oldest note; an answer with no note is a fault.
    // Looked at mid-cycle, where the registered answer has settled
    always @(negedge core_clk) begin
        if (mem_ack === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk(32'h1, 32'h0);
            end else begin
                e = exp_q.pop_front();
                if (e[8])
                    chk({24'h0, mem_rdata}, {24'h0, e[7:0]});
            end
        end
    end

    // Reset, then count the boot walk while a refused request is tried
    task automatic do_reset();
        reset = 1'b1;
        foreach (iram_m[i]) iram_m[i] = 8'h00;
        repeat (20) @(posedge core_clk);
        chk({28'h0, dsp_idle, tw_scl_hold_high, tw_sda_hold_high, boot_busy}, 32'hF);
        #1;
        reset = 1'b0;
        n = 0;
        fork
            while (boot_busy === 1'b1 && n < 5000) begin
                @(posedge core_clk);
                #1;
                n++;
            end
            u_core.acc(1'b0, 3'h4, 16'hFFC8, 8'h00, 1'b0, ok);
        join
        chk({31'h0, ok}, 32'h0);
        chk(n, 32'd2307);
        chk({29'h0, dsp_idle, tw_scl_hold_high, tw_sda_hold_high}, 32'h0);
        chk({31'h0, delay_clear_req}, 32'h1);
        chk({8'h0, output_mute_ctl_a, output_mute_ctl_b, output_mute_ctl_c}, 32'h0);
        chk({16'h0, dac_mod_reset, adc_dec_reset}, 32'hFF03);
        chk({16'h0, clock_config_primary, clock_skew_config_secondary}, 32'h0A05);
        chk({31'h0, fetch_from_ram}, 32'h0);
        for (int i = 0; i < 256; i++) rd(3'h1, i[15:0], 8'h00);
    endtask

    // Watchdog sized well above the two boots and sweeps
    initial begin
        #(5 * 60000);
        errors++;
        finish_test();
    end

    initial begin
        errors = 0;
        checks_done = 0;
        r = 16'd57899;
        do_reset();
        for (int i = 0; i < 2048; i++) rd(3'h4, i[15:0], 8'h00);
        // Random indirect bytes over the whole 256, stack region included
        for (int i = 0; i < 24; i++) begin
            r = lfsr_next(r);
            wr(3'h1, {8'h00, r[15:8]}, r[7:0], 1'b0);
            iram_m[r[15:8]] = r[7:0];
        end
        // Direct lower half lands in the same bytes as indirect
        for (int k = 0; k < 3; k++) begin
            r = lfsr_next(r);
            wr(3'h0, {8'h00, 8'h30 + 8'(k * 37)}, r[7:0], 1'b0);
            iram_m[8'h30 + 8'(k * 37)] = r[7:0];
        end
        // Direct upper half reaches the extended registers, not RAM
        rd(3'h0, 16'h00C8, 8'h0A);
        wr(3'h0, 16'h00C1, 8'h5A, 1'b0);
        chk({24'h0, output_mute_ctl_a}, 32'h5A);
        rd(3'h1, 16'h00C1, iram_m[8'hC1]);
        rd(3'h4, 16'hFFC1, 8'h5A);
        rd(3'h4, 16'h1234, 8'h00);
        wr(3'h4, 16'h07FF, r[15:8], 1'b0);
        rd(3'h4, 16'h07FF, r[15:8]);
        // Register slot 5 of each bank
        for (int b = 0; b < 4; b++) begin
            u_core.bank_sel = b[1:0];
            r = lfsr_next(r);
            wr(3'h2, 16'h0005, r[7:0], 1'b0);
            iram_m[{3'h0, b[1:0], 3'h5}] = r[7:0];
        end
        // Bit ops in the bit bytes and in an addressable extended register
        wr(3'h3, 16'h000B, 8'h00, 1'b1);
        iram_m[8'h21][3] = 1'b1;
        rd(3'h3, 16'h000B, 8'h01);
        rd(3'h3, 16'h00C9, 8'h01);
        wr(3'h3, 16'h00C9, 8'h00, 1'b0);
        chk({24'h0, clock_config_primary}, 32'h08);
        wr(3'h0, 16'h00FD, 8'h01, 1'b0);
        chk({31'h0, fetch_from_ram}, 32'h1);
        for (int i = 0; i < 256; i++) rd(3'h1, i[15:0], iram_m[i]);
        // Second reset mid-run must redo the whole walk
        do_reset();
        rd(3'h4, 16'h07FF, 8'h00);
        repeat (3) @(posedge core_clk);
        chk(exp_q.size(), 32'h0);
        finish_test();
    end
endmodule

// ---- test/mbi_core_model.sv ----
`timescale 1ns/100ps
// Stand-in for the controller core: one request at a time, fields held until answered
module mbi_core_model (
    input wire logic core_clk,
    input wire logic mem_ack,
    output logic mem_req,
    output logic mem_we,
    output logic [2:0] mem_space,
    output logic [15:0] mem_addr,
    output logic [7:0] mem_wdata,
    output logic mem_bitval,
    output logic [1:0] bank_sel
);
    // Quiet bus at time zero; a two-bit select can only ever name one bank
    initial begin
        mem_req = 1'b0;
        mem_we = 1'b0;
        mem_space = 3'h0;
        mem_addr = 16'h0000;
        mem_wdata = 8'h00;
        mem_bitval = 1'b0;
        bank_sel = 2'h0;
    end

    // Request lasts one taking edge; the other fields stay until the answer edge
    task automatic acc(input logic we, input logic [2:0] sp, input logic [15:0] ad,
                       input logic [7:0] wd, input logic bv, output logic ok);
        int n;
        @(posedge core_clk);
        #1;
        mem_req = 1'b1;
        mem_we = we;
        mem_space = sp;
        mem_addr = ad;
        mem_wdata = wd;
        mem_bitval = bv;
        @(posedge core_clk);
        #1;
        mem_req = 1'b0;
        n = 0;
        while (mem_ack !== 1'b1 && n < 8) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        ok = (mem_ack === 1'b1);
        @(posedge core_clk);
        #1;
        // Released write flag, address, data and bit value turn over so stale values cannot pass for fresh ones; space stays
        mem_we = ~mem_we;
        mem_addr = ~mem_addr;
        mem_wdata = ~mem_wdata;
        mem_bitval = ~mem_bitval;
    endtask
endmodule
